// [rtl/otg_host_session.sv]
`timescale 1ns/1ps
`default_nettype none
module otg_host_session #(
  parameter int DETACH_CYCLES = otg_host_pkg::DETACH_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Link-side packet engine
  output logic pkt_valid_o,
  output otg_host_pkg::packet_t pkt_o,
  input wire logic pkt_done_i,
  input wire logic [3:0] hs_pid_i,
  input wire logic hs_error_i,
  input wire logic se0_i,
  input wire logic attach_i,
  // Analog and external comparators
  input wire logic int_sess_end_i,
  input wire logic int_sess_valid_i,
  input wire logic int_vbus_valid_i,
  input wire logic comparator_status_input_1,
  input wire logic comparator_status_input_2,
  input wire logic vbus_valid_input,
  input wire logic session_valid_input,
  input wire logic session_end_input,
  output logic vbus_power_on_o,
  output logic vbus_discharge_o,
  output logic vbus_pulse_o,
  output logic dplus_pullup_o,
  output logic dminus_pullup_o,
  output logic low_speed_o
);
  typedef struct packed {
    otg_host_pkg::xfer_state_t st;
    logic [7:0] ep0;
    logic [6:0] taddr;
    logic [3:0] tok_pid;
    logic [3:0] tok_ep;
    logic [7:0] irq;
    logic [7:0] otg_ctrl;
    logic [7:0] otg_irq;
    logic [7:0] cfg2;
    logic desc_own;
    logic [3:0] desc_pid;
    logic [6:0] desc_len;
    logic [11:0] se0_cnt;
    logic detached;
    logic [7:0] rdata;
    otg_host_pkg::vbus_band_t band;
    logic [1:0] band_prev;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] e1;
    logic [2:0] e2;
  } state_t;
  state_t q, d;
  logic [11:0] detach_lim;
  assign detach_lim = 12'(DETACH_CYCLES);
  function automatic otg_host_pkg::vbus_band_t decode_band(input logic sel,
                                                           input logic [2:0] p);
    decode_band = otg_host_pkg::BAND_BELOW_END;
    if (!sel)
    begin
      unique case (p[1:0])
        2'b00: decode_band = otg_host_pkg::BAND_BELOW_END;
        2'b01: decode_band = otg_host_pkg::BAND_END_TO_VALID;
        2'b10: decode_band = otg_host_pkg::BAND_VALID_TO_VBUS;
        2'b11: decode_band = otg_host_pkg::BAND_ABOVE;
      endcase
    end
    else
    begin
      unique case (p)
        3'b001: decode_band = otg_host_pkg::BAND_BELOW_END;
        3'b000: decode_band = otg_host_pkg::BAND_END_TO_VALID;
        3'b010: decode_band = otg_host_pkg::BAND_VALID_TO_VBUS;
        3'b110: decode_band = otg_host_pkg::BAND_ABOVE;
        // Illegal external pattern: treat as no session
        default: decode_band = otg_host_pkg::BAND_BELOW_END;
      endcase
    end
  endfunction
  logic [2:0] ext_pat;
  logic [2:0] int_pat;
  logic [1:0] ib;
  logic sess_end_now;
  logic sess_valid_now;
  always_comb
  begin
    d = q;
    ext_pat = 3'h0;
    int_pat = 3'h0;
    ib = 2'h0;
    // Pins pass two flops first; s1/e1 feed only s2/e2
    d.s1 = {int_vbus_valid_i, int_sess_valid_i, int_sess_end_i};
    d.s2 = q.s1;
    d.e1 = q.cfg2[otg_host_pkg::CFG2_PIN_SET_SEL]
      ? {vbus_valid_input, session_valid_input, session_end_input}
      : {1'b0, comparator_status_input_2, comparator_status_input_1};
    d.e2 = q.e1;
    int_pat = q.s2;
    ib = int_pat[2] ? 2'b11 : int_pat[1] ? 2'b10 : int_pat[0] ? 2'b00 : 2'b01;
    ext_pat = q.e2;
    if (q.cfg2[otg_host_pkg::CFG2_COMP_DISABLE])
      d.band = decode_band(q.cfg2[otg_host_pkg::CFG2_PIN_SET_SEL], ext_pat);
    else
      d.band = decode_band(1'b1, {ib == 2'b11, ib[1], ib == 2'b00});
    d.band_prev = q.band;
    sess_end_now = (q.band == otg_host_pkg::BAND_BELOW_END);
    sess_valid_now = (q.band == otg_host_pkg::BAND_VALID_TO_VBUS)
                     || (q.band == otg_host_pkg::BAND_ABOVE);
    d.rdata = 8'h00;
    // Software writes: one clears, hardware set below wins
    if (wr_i)
    begin
      unique case (addr_i)
        otg_host_pkg::ADDR_EP0_CTRL: d.ep0 = wdata_i;
        otg_host_pkg::ADDR_TARGET: d.taddr = wdata_i[6:0];
        otg_host_pkg::ADDR_TOKEN:
        begin
          d.tok_pid = wdata_i[7:4];
          d.tok_ep = wdata_i[3:0];
        end
        otg_host_pkg::ADDR_IRQ_FLAGS: d.irq = q.irq & ~wdata_i;
        otg_host_pkg::ADDR_OTG_CTRL: d.otg_ctrl = wdata_i;
        otg_host_pkg::ADDR_OTG_IRQ: d.otg_irq = q.otg_irq & ~wdata_i;
        otg_host_pkg::ADDR_CFG2: d.cfg2 = wdata_i;
        otg_host_pkg::ADDR_DESC:
        begin
          d.desc_own = wdata_i[otg_host_pkg::DESC_OWN];
          d.desc_len = (wdata_i[6:0] > otg_host_pkg::MAX_PAYLOAD)
                       ? otg_host_pkg::MAX_PAYLOAD : wdata_i[6:0];
        end
        default: ;
      endcase
    end
    if (rd_i)
    begin
      unique case (addr_i)
        otg_host_pkg::ADDR_EP0_CTRL: d.rdata = q.ep0;
        otg_host_pkg::ADDR_TARGET: d.rdata = {1'b0, q.taddr};
        otg_host_pkg::ADDR_TOKEN: d.rdata = {q.tok_pid, q.tok_ep};
        otg_host_pkg::ADDR_IRQ_FLAGS: d.rdata = q.irq;
        otg_host_pkg::ADDR_OTG_CTRL: d.rdata = q.otg_ctrl;
        otg_host_pkg::ADDR_OTG_IRQ: d.rdata = q.otg_irq;
        otg_host_pkg::ADDR_CFG2: d.rdata = q.cfg2;
        otg_host_pkg::ADDR_DESC: d.rdata = {q.desc_own, 3'h0, q.desc_pid};
        otg_host_pkg::ADDR_VBUS_BAND: d.rdata = {6'h00, q.band};
        default: d.rdata = 8'h00;
      endcase
    end
    // Set after the clear so a band change in the clearing cycle is kept
    if (q.band != otg_host_pkg::vbus_band_t'(q.band_prev))
    begin
      if (sess_end_now)
        d.otg_irq[otg_host_pkg::OTGIR_SESSION_END] = 1'b1;
      if (sess_valid_now)
        d.otg_irq[otg_host_pkg::OTGIR_SESSION_VALID] = 1'b1;
    end
    // Detach: SE0 held past the limit
    if (!q.s2[0] && se0_i)
    begin
      if (q.se0_cnt < detach_lim)
        d.se0_cnt = q.se0_cnt + 12'h001;
      else if (!q.detached)
      begin
        d.irq[otg_host_pkg::IRQ_DETACH] = 1'b1;
        d.detached = 1'b1;
      end
    end
    else
    begin
      d.se0_cnt = 12'h000;
      d.detached = 1'b0;
    end
    if (attach_i)
      d.irq[otg_host_pkg::IRQ_ATTACH] = 1'b1;
    unique case (q.st)
      otg_host_pkg::ST_IDLE:
        if (wr_i && addr_i == otg_host_pkg::ADDR_TOKEN && q.desc_own
            && wdata_i[7:4] == otg_host_pkg::PID_OUT)
          d.st = otg_host_pkg::ST_TOKEN;
      otg_host_pkg::ST_TOKEN:
        d.st = otg_host_pkg::ST_DATA;
      otg_host_pkg::ST_DATA:
        d.st = otg_host_pkg::ST_WAIT;
      otg_host_pkg::ST_WAIT:
        if (pkt_done_i)
        begin
          if (!hs_error_i && hs_pid_i == otg_host_pkg::PID_NAK
              && !q.ep0[otg_host_pkg::EP0_RETRY_DISABLE])
            d.st = otg_host_pkg::ST_TOKEN;
          else
          begin
            d.st = otg_host_pkg::ST_DONE;
            if (q.ep0[otg_host_pkg::EP0_RETRY_DISABLE])
              d.desc_pid = hs_error_i ? otg_host_pkg::PID_ERROR : hs_pid_i;
            else
              d.desc_pid = hs_pid_i;
          end
        end
      otg_host_pkg::ST_DONE:
      begin
        d.desc_own = 1'b0;
        d.irq[otg_host_pkg::IRQ_TRANSFER_DONE] = 1'b1;
        d.st = otg_host_pkg::ST_IDLE;
      end
      default: d.st = otg_host_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      q <= '0;
      q.ep0 <= otg_host_pkg::EP0_RESET;
    end
    else
      q <= d;
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pkt_valid_o <= 1'b0;
      pkt_o <= '0;
      rdata_o <= 8'h00;
      vbus_power_on_o <= 1'b0;
      vbus_discharge_o <= 1'b0;
      vbus_pulse_o <= 1'b0;
      dplus_pullup_o <= 1'b0;
      dminus_pullup_o <= 1'b0;
      low_speed_o <= 1'b0;
    end
    else
    begin
      // Token then data: one pulse each
      pkt_valid_o <= (d.st == otg_host_pkg::ST_TOKEN) || (d.st == otg_host_pkg::ST_DATA);
      // Next-state fields: the token write and the first token share one edge
      pkt_o.pid <= (d.st == otg_host_pkg::ST_TOKEN) ? d.tok_pid : 4'h3;
      pkt_o.endp <= d.tok_ep;
      pkt_o.dev_addr <= d.taddr;
      pkt_o.low_speed <= d.ep0[otg_host_pkg::EP0_LOW_SPEED];
      pkt_o.len <= d.desc_len;
      rdata_o <= d.rdata;
      vbus_power_on_o <= d.otg_ctrl[otg_host_pkg::OTG_VBUS_ON];
      vbus_discharge_o <= d.otg_ctrl[otg_host_pkg::OTG_VBUS_DISCHARGE];
      vbus_pulse_o <= d.cfg2[otg_host_pkg::CFG2_VBUS_PULSE];
      dplus_pullup_o <= d.otg_ctrl[otg_host_pkg::OTG_DPLUS_PULLUP];
      dminus_pullup_o <= d.otg_ctrl[otg_host_pkg::OTG_DMINUS_PULLUP];
      low_speed_o <= d.ep0[otg_host_pkg::EP0_LOW_SPEED];
    end
  end
  sequence s_token_then_data;
    pkt_valid_o && pkt_o.pid == otg_host_pkg::PID_OUT
    ##1 pkt_valid_o && pkt_o.pid == 4'h3;
  endsequence
  sequence s_retry_pair;
    q.st == otg_host_pkg::ST_TOKEN ##1 q.st == otg_host_pkg::ST_DATA;
  endsequence
  a_out_start: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.st == otg_host_pkg::ST_IDLE && wr_i && addr_i == otg_host_pkg::ADDR_TOKEN
     && q.desc_own && wdata_i[7:4] == otg_host_pkg::PID_OUT)
    |=> q.st == otg_host_pkg::ST_TOKEN)
    else $error("out token not started");
  a_token_data: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.st == otg_host_pkg::ST_TOKEN) |-> s_token_then_data)
    else $error("token not followed by data");
  a_nak_retry: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.st == otg_host_pkg::ST_WAIT && pkt_done_i && !hs_error_i
     && hs_pid_i == otg_host_pkg::PID_NAK && !q.ep0[6])
    |=> s_retry_pair)
    else $error("nak not retried");
  a_error_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.st == otg_host_pkg::ST_WAIT && pkt_done_i && hs_error_i && q.ep0[6])
    |=> q.desc_pid == otg_host_pkg::PID_ERROR)
    else $error("error code missing");
  a_done_flag: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.st == otg_host_pkg::ST_DONE) |=> q.irq[3] && !q.desc_own)
    else $error("done flag or ownership wrong");
  a_detach_time: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(q.irq[0]) |-> q.se0_cnt == detach_lim)
    else $error("detach at wrong time");
  a_token_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.st == otg_host_pkg::ST_TOKEN) |-> pkt_o.dev_addr == q.taddr)
    else $error("wrong device address");
  a_vbus_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == otg_host_pkg::ADDR_OTG_CTRL && !wdata_i[3])
    |=> !vbus_power_on_o)
    else $error("vbus stayed on");
  a_discharge: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == otg_host_pkg::ADDR_OTG_CTRL)
    |=> vbus_discharge_o == $past(wdata_i[0]))
    else $error("discharge mismatch");
  a_dplus_grant: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == otg_host_pkg::ADDR_OTG_CTRL)
    |=> dplus_pullup_o == $past(wdata_i[7]))
    else $error("dplus pullup mismatch");
  a_sess_end: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.band == otg_host_pkg::BAND_BELOW_END && q.band_prev != 2'b00)
    |=> q.otg_irq[2])
    else $error("session end flag missing");
  a_ext_band: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (q.cfg2[1] && !q.cfg2[5] && q.e2[1:0] == 2'b11 && $stable(q.cfg2))
    |=> q.band == otg_host_pkg::BAND_ABOVE)
    else $error("external band decode wrong");
endmodule
`default_nettype wire

// [inc/otg_host_pkg.sv]
`default_nettype none
package otg_host_pkg;
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] ADDR_EP0_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TARGET = 8'h04;
  localparam logic [7:0] ADDR_TOKEN = 8'h08;
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_OTG_CTRL = 8'h10;
  localparam logic [7:0] ADDR_OTG_IRQ = 8'h14;
  localparam logic [7:0] ADDR_CFG2 = 8'h18;
  localparam logic [7:0] ADDR_DESC = 8'h1C;
  localparam logic [7:0] ADDR_VBUS_BAND = 8'h20;
  // Field positions
  localparam int EP0_LOW_SPEED = 7;
  localparam int EP0_RETRY_DISABLE = 6;
  localparam int IRQ_DETACH = 0;
  localparam int IRQ_TRANSFER_DONE = 3;
  localparam int IRQ_ATTACH = 6;
  localparam int OTG_DPLUS_PULLUP = 7;
  localparam int OTG_DMINUS_PULLUP = 6;
  localparam int OTG_VBUS_ON = 3;
  localparam int OTG_VBUS_DISCHARGE = 0;
  localparam int OTGIR_SESSION_END = 2;
  localparam int OTGIR_SESSION_VALID = 3;
  localparam int CFG2_COMP_DISABLE = 1;
  localparam int CFG2_VBUS_PULSE = 4;
  localparam int CFG2_PIN_SET_SEL = 5;
  localparam int DESC_OWN = 7;
  // Token and handshake codes, then the EP0 reset value and the payload limit
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [3:0] PID_STALL = 4'hE;
  localparam logic [3:0] PID_ERROR = 4'hF;
  localparam logic [7:0] EP0_RESET = 8'h00;
  localparam logic [6:0] MAX_PAYLOAD = 7'h40;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int DETACH_NS = 2500;
  localparam int DETACH_CYCLES = (DETACH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // VBUS bands, low to high
  typedef enum logic [1:0] {
    BAND_BELOW_END = 2'b00,
    BAND_END_TO_VALID = 2'b01,
    BAND_VALID_TO_VBUS = 2'b11,
    BAND_ABOVE = 2'b10
  } vbus_band_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_TOKEN = 3'b001,
    ST_DATA = 3'b011,
    ST_WAIT = 3'b010,
    ST_DONE = 3'b110
  } xfer_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic [3:0] pid;
    logic [3:0] endp;
    logic [6:0] dev_addr;
    logic low_speed;
    logic [6:0] len;
  } packet_t;
endpackage
`default_nettype wire

// [tb/usb_far_model.sv]
`timescale 1ns/1ps
`default_nettype none
module usb_far_model (
  input wire logic clk_i,
  input wire logic pkt_valid_i,
  input wire otg_host_pkg::packet_t pkt_i,
  input wire logic [3:0] nak_cnt_i,
  input wire logic [3:0] fin_pid_i,
  input wire logic fin_err_i,
  input wire logic [3:0] delay_i,
  output logic pkt_done_o,
  output logic [3:0] hs_pid_o,
  output logic hs_error_o,
  output logic [7:0] tok_cnt_o,
  output otg_host_pkg::packet_t tok_o,
  output otg_host_pkg::packet_t dat_o
);
  int naks;
  initial
  begin
    pkt_done_o = 1'b0;
    hs_pid_o = 4'h5;
    hs_error_o = 1'b0;
    tok_cnt_o = 8'h00;
    tok_o = '0;
    dat_o = '0;
    naks = 0;
    forever
    begin
      @(posedge clk_i);
      if (pkt_valid_i === 1'b1 && pkt_i.pid === otg_host_pkg::PID_OUT)
      begin
        tok_o <= pkt_i;
        tok_cnt_o <= tok_cnt_o + 8'h01;
        // Data packet rides the cycle right after its token
        @(posedge clk_i);
        dat_o <= pkt_i;
        repeat (delay_i) @(posedge clk_i);
        pkt_done_o <= 1'b1;
        if (naks < int'(nak_cnt_i))
        begin
          hs_pid_o <= otg_host_pkg::PID_NAK;
          hs_error_o <= 1'b0;
          naks++;
        end
        else
        begin
          hs_pid_o <= fin_pid_i;
          hs_error_o <= fin_err_i;
          naks = 0;
        end
        @(posedge clk_i);
        // Stale handshake lines must never look like a fresh answer
        pkt_done_o <= 1'b0;
        hs_pid_o <= ~hs_pid_o;
        hs_error_o <= ~hs_error_o;
      end
    end
  end
endmodule
`default_nettype wire

// [tb/test_usb_otg_host_session_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_usb_otg_host_session_control;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic se0_i = 1'b0;
  logic attach_i = 1'b0;
  logic [1:0] pins2 = 2'b00;
  logic [2:0] pins3 = 3'b000;
  logic [3:0] nak_cnt = 4'h0;
  logic [3:0] fin_pid = 4'h2;
  logic fin_err = 1'b0;
  logic [3:0] delay = 4'h0;
  logic [7:0] rdata_o;
  logic pkt_valid_o;
  otg_host_pkg::packet_t pkt_o;
  otg_host_pkg::packet_t tok;
  otg_host_pkg::packet_t dat;
  logic pkt_done;
  logic [3:0] hs_pid;
  logic hs_error;
  logic [7:0] tok_cnt;
  logic [7:0] t0;
  logic [7:0] v;
  logic [5:0] lvl;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [3:0] codes [4] = '{4'h2, 4'hA, 4'hE, 4'h2};
  logic [3:0] stored [4] = '{4'h2, 4'hA, 4'hE, 4'hF};
  logic [1:0] p2 [4] = '{2'b00, 2'b10, 2'b01, 2'b11};
  logic [2:0] p3 [4] = '{3'b001, 3'b000, 3'b010, 3'b110};
  logic [1:0] bands [4] = '{2'b00, 2'b01, 2'b11, 2'b10};

  otg_host_session #(.DETACH_CYCLES(4)) i_otg_host_session (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pkt_valid_o(pkt_valid_o),
    .pkt_o(pkt_o), .pkt_done_i(pkt_done), .hs_pid_i(hs_pid), .hs_error_i(hs_error),
    .se0_i(se0_i), .attach_i(attach_i), .int_sess_end_i(1'b0),
    .int_sess_valid_i(1'b1), .int_vbus_valid_i(1'b1),
    .comparator_status_input_1(pins2[1]), .comparator_status_input_2(pins2[0]),
    .vbus_valid_input(pins3[2]), .session_valid_input(pins3[1]),
    .session_end_input(pins3[0]), .vbus_power_on_o(lvl[5]),
    .vbus_discharge_o(lvl[4]), .vbus_pulse_o(lvl[3]), .dplus_pullup_o(lvl[2]),
    .dminus_pullup_o(lvl[1]), .low_speed_o(lvl[0])
  );

  usb_far_model i_usb_far_model (
    .clk_i(clk_i), .pkt_valid_i(pkt_valid_o), .pkt_i(pkt_o), .nak_cnt_i(nak_cnt),
    .fin_pid_i(fin_pid), .fin_err_i(fin_err), .delay_i(delay), .pkt_done_o(pkt_done),
    .hs_pid_o(hs_pid), .hs_error_o(hs_error), .tok_cnt_o(tok_cnt), .tok_o(tok),
    .dat_o(dat)
  );

  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
    checks_done++;
    if ((got & m) !== (exp & m))
    begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_pkt(input logic [22:0] got, input logic [22:0] exp, input logic [22:0] m);
    checks_done++;
    if ((got & m) !== (exp & m))
    begin
      fail_count++;
      $display("[ERR] %0t packet %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
    rd(a);
    chk(v, exp, m);
  endtask

  // Polls instead of fixed wait: NAK retries make the length open
  task automatic wait_done;
    v = 8'h00;
    for (int n = 0; n < 100 && v[3] !== 1'b1; n++)
      rd(otg_host_pkg::ADDR_IRQ_FLAGS);
    chk(v, 8'h08, 8'h08);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[ERR] %0t timeout", $time);
      finish_test;
    end
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk({2'b00, lvl}, 8'h00, 8'hFF);
    rdc(8'h30, 8'h00, 8'hFF);
    // Low speed, retries on, slow target naking twice
    wr(otg_host_pkg::ADDR_EP0_CTRL, 8'h9D);
    wr(otg_host_pkg::ADDR_TARGET, 8'h85);
    wr(otg_host_pkg::ADDR_DESC, 8'hC0);
    nak_cnt <= 4'h2;
    delay <= 4'h5;
    t0 = tok_cnt;
    wr(otg_host_pkg::ADDR_TOKEN, 8'h13);
    wait_done;
    chk(tok_cnt - t0, 8'h03, 8'hFF);
    chk_pkt(tok, {4'h1, 4'h3, 7'h05, 1'b1, 7'h00}, 23'h7FFF80);
    chk_pkt(dat, {4'h3, 4'h0, 7'h00, 1'b0, 7'h40}, 23'h78007F);
    rdc(otg_host_pkg::ADDR_DESC, 8'h02, 8'h8F);
    chk({2'b00, lvl}, 8'h01, 8'h01);
    wr(otg_host_pkg::ADDR_IRQ_FLAGS, 8'h08);
    rdc(otg_host_pkg::ADDR_IRQ_FLAGS, 8'h00, 8'h08);
    $display("bulk retry test done");
    // Retries off, prompt target, every handshake kind
    wr(otg_host_pkg::ADDR_EP0_CTRL, 8'h5D);
    nak_cnt <= 4'h0;
    delay <= 4'h0;
    for (int i = 0; i < 4; i++)
    begin
      fin_pid <= codes[i];
      fin_err <= (i == 3);
      t0 = tok_cnt;
      wr(otg_host_pkg::ADDR_DESC, 8'h88);
      wr(otg_host_pkg::ADDR_TOKEN, 8'h10);
      wait_done;
      rdc(otg_host_pkg::ADDR_DESC, {4'h0, stored[i]}, 8'h8F);
      chk(tok_cnt - t0, 8'h01, 8'hFF);
      wr(otg_host_pkg::ADDR_IRQ_FLAGS, 8'h08);
    end
    // Token refused without ownership, and for a non-OUT code
    t0 = tok_cnt;
    wr(otg_host_pkg::ADDR_TOKEN, 8'h10);
    wr(otg_host_pkg::ADDR_DESC, 8'h88);
    wr(otg_host_pkg::ADDR_TOKEN, 8'h90);
    repeat (10) @(posedge clk_i);
    chk(tok_cnt - t0, 8'h00, 8'hFF);
    rdc(otg_host_pkg::ADDR_DESC, 8'h80, 8'h80);
    $display("handshake test done");
    // Short single-ended zero is a glitch, a long one a detach
    se0_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    se0_i <= 1'b0;
    rdc(otg_host_pkg::ADDR_IRQ_FLAGS, 8'h00, 8'h01);
    se0_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    se0_i <= 1'b0;
    attach_i <= 1'b1;
    @(posedge clk_i);
    attach_i <= 1'b0;
    rdc(otg_host_pkg::ADDR_IRQ_FLAGS, 8'h41, 8'h41);
    $display("detach test done");
    wr(otg_host_pkg::ADDR_OTG_CTRL, 8'hC9);
    wr(otg_host_pkg::ADDR_CFG2, 8'h10);
    repeat (2) @(negedge clk_i);
    chk({2'b00, lvl}, 8'h3E, 8'hFF);
    wr(otg_host_pkg::ADDR_OTG_CTRL, 8'h48);
    repeat (2) @(negedge clk_i);
    chk({2'b00, lvl}, 8'h2A, 8'hFF);
    wr(otg_host_pkg::ADDR_OTG_CTRL, 8'h00);
    repeat (2) @(negedge clk_i);
    chk({2'b00, lvl}, 8'h08, 8'hFF);
    $display("otg control test done");
    rdc(otg_host_pkg::ADDR_VBUS_BAND, 8'h02, 8'h03);
    for (int s = 0; s < 2; s++)
    begin
      wr(otg_host_pkg::ADDR_CFG2, (s == 0) ? 8'h02 : 8'h22);
      wr(otg_host_pkg::ADDR_OTG_IRQ, 8'hFF);
      for (int i = 0; i < 4; i++)
      begin
        // The unselected pin set shows a different band on purpose
        pins2 <= p2[(s == 0) ? i : 3 - i];
        pins3 <= p3[(s == 1) ? i : 3 - i];
        repeat (5) @(posedge clk_i);
        rdc(otg_host_pkg::ADDR_VBUS_BAND, {6'h00, bands[i]}, 8'h03);
      end
      rdc(otg_host_pkg::ADDR_OTG_IRQ, 8'h0C, 8'h0C);
    end
    $display("comparator test done");
    finish_test;
  end
endmodule
`default_nettype wire
